// File: ssd_decoder.sv
// Decoder and cycle costing for shift, subtract and compare forms
//
// Functional notes
// - Prefix byte 8'h09 ahead of the opcode marks an indirect destination.
// - Indirect destination adds one byte and three cycles.
// - Size bit 0 selects byte operation, 1 selects word.
// - Register codes: 12/13 first pair, 10/11 upper pair, 02/03 address.
// - Memory codes 00/01 and 04-0D by displacement; 0F is abs16, 0E is abs24.
// - Register-count forms: code 13 byte only; code 11 word only.
// - Register-count shifts cost 3 cycles on registers, 5 on memory.
// - Immediate subtract-with-borrow: 1 or 3 cycles; word adds a byte.
// - Branch displacement is target minus start minus two.
// - Subtract-branch immediate: 0 is 0, 1-7 minus, 8 plus 8, 9-F +7..+1.
// - Subtract-branch: 2 or 4 cycles, two more when taken.
// - Store-on-condition field decodes fourteen flag conditions.
// - Store-on-condition costs one cycle, two to five bytes.
// - String compare: 6+3m byte; word 6/9 or 8/10 plus 1.5m.
// - Immediate shift count: 0-7 mean +1..+8, 8-F mean -1..-8.
// - Immediate shifts cost 2 cycles on registers, 4 on memory.
// - Long immediate shift rejects the upper pair, 6 or 8 cycles.
`timescale 1ns/100ps

module ssd_decoder
    import ssd_pkg::*;
(
    // Clock and reset
    input  wire logic     CLK_IN,
    input  wire logic     RST_N_IN,
    // Decode request
    input  wire logic     REQ_VALID_IN,
    input  wire ssd_req_t REQ_IN,
    // Decode result
    output logic          DONE_OUT,
    output ssd_res_t      RESULT_OUT
);

    // ****************************************
    // Helpers
    // ****************************************
    // Register codes
    function automatic ssd_mode_t mode_of(input logic [4:0] code);
        ssd_mode_t m;
        m = SSD_MODE_UNDEF;
        case (code)
            SSD_OPD_GEN0, SSD_OPD_GEN1,
            SSD_OPD_UPPER0, SSD_OPD_UPPER1: m = SSD_MODE_GEN_REG;
            SSD_OPD_ADDR_ZERO, SSD_OPD_ADDR_ONE: m = SSD_MODE_ADDR_REG;
            5'h00, 5'h01: m = SSD_MODE_ADDR_IND;
            5'h04, 5'h05, 5'h06, 5'h07: m = SSD_MODE_BRANCH_DISPLACEMENT_BYTE;
            5'h08, 5'h09, 5'h0A, 5'h0B: m = SSD_MODE_DSP16;
            5'h0C, 5'h0D: m = SSD_MODE_DSP24;
            SSD_OPD_ABS16: m = SSD_MODE_ABS16;
            SSD_OPD_ABS24: m = SSD_MODE_ABS24;
            default: m = SSD_MODE_UNDEF;
        endcase
        return m;
    endfunction

    function automatic logic [3:0] disp_bytes(input ssd_mode_t m);
        logic [3:0] n;
        n = 4'h0;
        case (m)
            SSD_MODE_BRANCH_DISPLACEMENT_BYTE: n = 4'h1;
            SSD_MODE_DSP16, SSD_MODE_ABS16: n = 4'h2;
            SSD_MODE_DSP24, SSD_MODE_ABS24: n = 4'h3;
            default: n = 4'h0;
        endcase
        return n;
    endfunction

    function automatic logic is_mem(input ssd_mode_t m);
        return (m != SSD_MODE_GEN_REG) && (m != SSD_MODE_ADDR_REG);
    endfunction

    // Carry set means no borrow, so the unsigned tests use it directly
    function automatic logic cond_eval(input logic [3:0] cnd,
                                       input logic c, input logic z,
                                       input logic s, input logic o);
        logic r;
        r = 1'b0;
        case (cnd)
            4'h0: r = !c;
            4'h1: r = !c || z;
            4'h2: r = !z;
            4'h3: r = !s;
            4'h4: r = !o;
            4'h5: r = !((s ^ o) || z);
            4'h6: r = !(s ^ o);
            4'h8: r = c;
            4'h9: r = c && !z;
            4'hA: r = z;
            4'hB: r = s;
            4'hC: r = o;
            4'hD: r = (s ^ o) || z;
            4'hE: r = s ^ o;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic     done;
        ssd_res_t res;
    } ssd_state_t;

    ssd_state_t state;
    ssd_state_t next_state;
    ssd_mode_t  dmode;
    ssd_mode_t  smode;
    logic       mem_d;
    logic       mem_s;
    logic       dest_ok;
    logic [19:0] triple_m;
    logic [19:0] half_m;
    logic [23:0] disp_full;
    logic [7:0]  count_mag;

    assign dmode    = mode_of(REQ_IN.dest_code);
    assign smode    = mode_of(REQ_IN.src_code);
    assign mem_d    = is_mem(dmode);
    assign mem_s    = is_mem(smode);
    assign triple_m = {4'h0, REQ_IN.xfer_count} * 20'h00003;
    // Odd counts of half-cycles round up to a whole cycle
    assign half_m   = (triple_m + 20'h00001) >> 1;
    // Displacement from two bytes past the start address
    assign disp_full = REQ_IN.target_addr - REQ_IN.start_addr
                       - SSD_BRANCH_BIAS;
    assign count_mag = REQ_IN.count_high_byte[7]
                       ? 8'(-REQ_IN.count_high_byte)
                       : REQ_IN.count_high_byte;

    // ****************************************
    // Operand legality
    // ****************************************
    always_comb begin
        dest_ok = (dmode != SSD_MODE_UNDEF);
        case (REQ_IN.op)
            SSD_CIRC_SHIFT_REG, SSD_ARITH_SHIFT_REG: begin
                if (REQ_IN.dest_code == SSD_OPD_GEN1) begin
                    dest_ok = (REQ_IN.size_word != SSD_SIZE_WORD);
                end else if (REQ_IN.dest_code == SSD_OPD_UPPER1) begin
                    dest_ok = (REQ_IN.size_word == SSD_SIZE_WORD);
                end
            end
            SSD_ARITH_SHIFT_LONG_IMM: begin
                if (REQ_IN.dest_code == SSD_OPD_UPPER0 ||
                    REQ_IN.dest_code == SSD_OPD_UPPER1) begin
                    dest_ok = 1'b0;
                end
            end
            SSD_STRING_COMPARE: dest_ok = 1'b1;
            default: dest_ok = (dmode != SSD_MODE_UNDEF);
        endcase
    end

    // ****************************************
    // Decode and cost
    // ****************************************
    always_comb begin
        next_state      = state;
        next_state.done = REQ_VALID_IN;
        if (REQ_VALID_IN) begin
            next_state.res           = '0;
            next_state.res.dest_mode = dmode;
            next_state.res.indirect  = REQ_IN.lead_valid &&
                (REQ_IN.lead_byte == SSD_INDIRECT_PREFIX);
            next_state.res.legal = dest_ok &&
                (!REQ_IN.lead_valid || next_state.res.indirect);
            case (REQ_IN.op)
                SSD_CIRC_SHIFT_IMM, SSD_ARITH_SHIFT_IMM: begin
                    next_state.res.length = SSD_LEN_SHORT;
                    next_state.res.cycles = mem_d ? SSD_CYC_FOUR
                                                  : SSD_CYC_TWO;
                end
                SSD_CIRC_SHIFT_REG, SSD_ARITH_SHIFT_REG: begin
                    next_state.res.length = SSD_LEN_SHORT;
                    next_state.res.cycles = mem_d ? SSD_CYC_FIVE
                                                  : SSD_CYC_THREE;
                end
                SSD_ARITH_SHIFT_LONG_IMM: begin
                    next_state.res.length = SSD_LEN_MID;
                    next_state.res.cycles = mem_d ? SSD_CYC_EIGHT
                                                  : SSD_CYC_SIX;
                end
                SSD_SUB_BORROW_IMM: begin
                    next_state.res.length = SSD_LEN_SUB_IMM +
                        (REQ_IN.size_word ? SSD_LEN_WORD_IMM : 4'h0);
                    next_state.res.cycles = mem_d ? SSD_CYC_THREE
                                                  : SSD_CYC_ONE;
                end
                SSD_SUB_BORROW_REG: begin
                    next_state.res.legal = next_state.res.legal &&
                        (smode != SSD_MODE_UNDEF);
                    next_state.res.length = SSD_LEN_MID +
                        disp_bytes(smode);
                    if (mem_d && mem_s) begin
                        next_state.res.cycles = SSD_CYC_FOUR;
                    end else if (mem_d || mem_s) begin
                        next_state.res.cycles = SSD_CYC_THREE;
                    end else begin
                        next_state.res.cycles = SSD_CYC_ONE;
                    end
                end
                SSD_SUB_BRANCH_NZ: begin
                    next_state.res.length = SSD_LEN_MID;
                    next_state.res.cycles = (mem_d ? SSD_CYC_FOUR
                        : SSD_CYC_TWO) + (REQ_IN.branch_taken
                        ? SSD_CYC_TAKEN : 20'h00000);
                end
                SSD_STORE_ON_COND: begin
                    next_state.res.length = SSD_LEN_SHORT;
                    next_state.res.cycles = SSD_CYC_ONE;
                    next_state.res.legal = next_state.res.legal &&
                        (REQ_IN.cond_code != SSD_CND_HOLE_LOW) &&
                        (REQ_IN.cond_code != SSD_CND_HOLE_HIGH);
                end
                // Compare cost by size and end case
                default: begin
                    next_state.res.length = SSD_LEN_SHORT;
                    if (REQ_IN.size_word != SSD_SIZE_WORD) begin
                        next_state.res.cycles = SSD_CYC_SIX + triple_m;
                    end else if (REQ_IN.null_low) begin
                        next_state.res.cycles = half_m + (REQ_IN.mismatch
                            ? SSD_CYC_TEN : SSD_CYC_EIGHT);
                    end else begin
                        next_state.res.cycles = half_m + (REQ_IN.mismatch
                            ? SSD_CYC_NINE : SSD_CYC_SIX);
                    end
                end
            endcase
            if (REQ_IN.op != SSD_STRING_COMPARE) begin
                next_state.res.length = next_state.res.length +
                    disp_bytes(dmode);
                if (next_state.res.indirect) begin
                    next_state.res.length = next_state.res.length +
                        SSD_LEN_INDIRECT;
                    next_state.res.cycles = next_state.res.cycles +
                        SSD_CYC_INDIRECT;
                end
            end
            if (REQ_IN.op == SSD_CIRC_SHIFT_REG ||
                REQ_IN.op == SSD_ARITH_SHIFT_REG) begin
                next_state.res.shift_left   = !REQ_IN.count_high_byte[7];
                next_state.res.shift_amount = count_mag;
            end else begin
                next_state.res.shift_left   = !REQ_IN.imm_field[3];
                next_state.res.shift_amount =
                    {5'h00, REQ_IN.imm_field[2:0]} + 8'h01;
            end
            // Value subtracted is the negated field
            next_state.res.sub_value =
                5'(-{REQ_IN.imm_field[3], REQ_IN.imm_field});
            next_state.res.branch_disp   = disp_full[7:0];
            next_state.res.disp_in_range = (disp_full[23:7] == '0) ||
                                           (disp_full[23:7] == '1);
            next_state.res.cond_true = cond_eval(REQ_IN.cond_code,
                REQ_IN.flag_c, REQ_IN.flag_z, REQ_IN.flag_s,
                REQ_IN.flag_o);
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign DONE_OUT   = state.done;
    assign RESULT_OUT = state.res;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    property p_prefix;
        REQ_VALID_IN && REQ_IN.lead_valid &&
        REQ_IN.lead_byte == 8'h09 |=> RESULT_OUT.indirect && DONE_OUT;
    endproperty
    a_prefix: assert property (p_prefix)
        else $error("prefix byte not taken as indirect");

    property p_ind_cost;
        REQ_VALID_IN && REQ_IN.op == SSD_STORE_ON_COND &&
        REQ_IN.lead_valid && REQ_IN.lead_byte == 8'h09 &&
        REQ_IN.dest_code == 5'h12
        |=> RESULT_OUT.length == 4'h3 && RESULT_OUT.cycles == 20'h4;
    endproperty
    a_ind_cost: assert property (p_ind_cost)
        else $error("indirect surcharge wrong");

    property p_word_imm;
        REQ_VALID_IN && REQ_IN.op == SSD_SUB_BORROW_IMM &&
        !REQ_IN.lead_valid && REQ_IN.dest_code == 5'h02
        |=> RESULT_OUT.length == ($past(REQ_IN.size_word) ? 4'h5 : 4'h4);
    endproperty
    a_word_imm: assert property (p_word_imm)
        else $error("size bit length wrong");

    property p_abs24;
        REQ_VALID_IN && REQ_IN.dest_code == 5'h0E
        |=> RESULT_OUT.dest_mode == SSD_MODE_ABS24;
    endproperty
    a_abs24: assert property (p_abs24)
        else $error("abs24 code misdecoded");

    property p_count_reg;
        REQ_VALID_IN && REQ_IN.op == SSD_ARITH_SHIFT_REG &&
        REQ_IN.size_word && REQ_IN.dest_code == 5'h13 |=> !RESULT_OUT.legal;
    endproperty
    a_count_reg: assert property (p_count_reg)
        else $error("count register accepted");

    property p_reg_shift;
        REQ_VALID_IN && REQ_IN.op == SSD_CIRC_SHIFT_REG &&
        !REQ_IN.lead_valid && REQ_IN.dest_code == 5'h0C
        |=> RESULT_OUT.cycles == 20'h5 && RESULT_OUT.length == 4'h5;
    endproperty
    a_reg_shift: assert property (p_reg_shift)
        else $error("register-count shift cost wrong");

    property p_disp;
        REQ_VALID_IN |=> RESULT_OUT.branch_disp == 8'($past(
            REQ_IN.target_addr) - $past(REQ_IN.start_addr) - 24'h2);
    endproperty
    a_disp: assert property (p_disp)
        else $error("branch displacement wrong");

    property p_taken;
        REQ_VALID_IN && REQ_IN.op == SSD_SUB_BRANCH_NZ &&
        !REQ_IN.lead_valid && REQ_IN.dest_code == 5'h12 &&
        REQ_IN.branch_taken |=> RESULT_OUT.cycles == 20'h4;
    endproperty
    a_taken: assert property (p_taken)
        else $error("taken branch cost wrong");

    property p_equal;
        REQ_VALID_IN && REQ_IN.cond_code == SSD_CND_EQUAL
        |=> RESULT_OUT.cond_true == $past(REQ_IN.flag_z);
    endproperty
    a_equal: assert property (p_equal)
        else $error("equal condition wrong");

    property p_str_byte;
        REQ_VALID_IN && REQ_IN.op == SSD_STRING_COMPARE &&
        !REQ_IN.size_word |=> RESULT_OUT.cycles ==
        20'(6 + 3 * $past(REQ_IN.xfer_count));
    endproperty
    a_str_byte: assert property (p_str_byte)
        else $error("byte compare cost wrong");

    property p_neg8;
        REQ_VALID_IN && REQ_IN.op == SSD_ARITH_SHIFT_IMM &&
        REQ_IN.imm_field == 4'hF
        |=> !RESULT_OUT.shift_left && RESULT_OUT.shift_amount == 8'h08;
    endproperty
    a_neg8: assert property (p_neg8)
        else $error("immediate count decode wrong");

    property p_undef;
        REQ_VALID_IN && REQ_IN.op != SSD_STRING_COMPARE &&
        REQ_IN.dest_code == 5'h14 |=> !RESULT_OUT.legal;
    endproperty
    a_undef: assert property (p_undef)
        else $error("undefined code accepted");

    c_indirect: cover property (REQ_VALID_IN ##1 RESULT_OUT.indirect);
    c_taken: cover property (REQ_VALID_IN && REQ_IN.branch_taken &&
        REQ_IN.op == SSD_SUB_BRANCH_NZ);
    c_word_cmp: cover property (REQ_VALID_IN && REQ_IN.size_word &&
        REQ_IN.op == SSD_STRING_COMPARE && REQ_IN.null_low);
    c_illegal: cover property (DONE_OUT && !RESULT_OUT.legal);

endmodule

// File: ssd_pkg.sv
// Shared codes, costs and carrier types of the decoder
package ssd_pkg;

    // ****************************************
    // Encodings
    // ****************************************
    localparam logic [7:0] SSD_INDIRECT_PREFIX = 8'h09;
    localparam logic       SSD_SIZE_WORD       = 1'h1;
    localparam logic [4:0] SSD_OPD_GEN0        = 5'h12;
    localparam logic [4:0] SSD_OPD_GEN1        = 5'h13;
    localparam logic [4:0] SSD_OPD_UPPER0      = 5'h10;
    localparam logic [4:0] SSD_OPD_UPPER1      = 5'h11;
    localparam logic [4:0] SSD_OPD_ADDR_ZERO   = 5'h02;
    localparam logic [4:0] SSD_OPD_ADDR_ONE    = 5'h03;
    localparam logic [4:0] SSD_OPD_ABS16       = 5'h0F;
    localparam logic [4:0] SSD_OPD_ABS24       = 5'h0E;
    localparam logic [3:0] SSD_CND_EQUAL       = 4'hA;
    localparam logic [3:0] SSD_CND_HOLE_LOW    = 4'h7;
    localparam logic [3:0] SSD_CND_HOLE_HIGH   = 4'hF;

    // ****************************************
    // Lengths and cycle costs
    // ****************************************
    localparam logic [3:0]  SSD_LEN_SHORT      = 4'h2;
    localparam logic [3:0]  SSD_LEN_MID        = 4'h3;
    localparam logic [3:0]  SSD_LEN_SUB_IMM    = 4'h4;
    localparam logic [3:0]  SSD_LEN_INDIRECT   = 4'h1;
    localparam logic [3:0]  SSD_LEN_WORD_IMM   = 4'h1;
    localparam logic [19:0] SSD_CYC_ONE        = 20'h00001;
    localparam logic [19:0] SSD_CYC_TWO        = 20'h00002;
    localparam logic [19:0] SSD_CYC_THREE      = 20'h00003;
    localparam logic [19:0] SSD_CYC_FOUR       = 20'h00004;
    localparam logic [19:0] SSD_CYC_FIVE       = 20'h00005;
    localparam logic [19:0] SSD_CYC_SIX        = 20'h00006;
    localparam logic [19:0] SSD_CYC_EIGHT      = 20'h00008;
    localparam logic [19:0] SSD_CYC_NINE       = 20'h00009;
    localparam logic [19:0] SSD_CYC_TEN        = 20'h0000A;
    localparam logic [19:0] SSD_CYC_INDIRECT   = 20'h00003;
    localparam logic [19:0] SSD_CYC_TAKEN      = 20'h00002;
    localparam logic [23:0] SSD_BRANCH_BIAS    = 24'h000002;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        SSD_CIRC_SHIFT_IMM, SSD_CIRC_SHIFT_REG, SSD_ARITH_SHIFT_IMM,
        SSD_ARITH_SHIFT_LONG_IMM, SSD_ARITH_SHIFT_REG,
        SSD_SUB_BORROW_IMM, SSD_SUB_BORROW_REG, SSD_SUB_BRANCH_NZ,
        SSD_STORE_ON_COND, SSD_STRING_COMPARE
    } ssd_op_t;

    typedef enum logic [3:0] {
        SSD_MODE_GEN_REG, SSD_MODE_ADDR_REG, SSD_MODE_ADDR_IND,
        SSD_MODE_BRANCH_DISPLACEMENT_BYTE, SSD_MODE_DSP16, SSD_MODE_DSP24,
        SSD_MODE_ABS16, SSD_MODE_ABS24, SSD_MODE_UNDEF
    } ssd_mode_t;

    typedef struct packed {
        ssd_op_t     op;
        logic        lead_valid;
        logic [7:0]  lead_byte;
        logic        size_word;
        logic [4:0]  dest_code;
        logic [4:0]  src_code;
        logic [3:0]  imm_field;
        logic [7:0]  count_high_byte;
        logic [3:0]  cond_code;
        logic        flag_c;
        logic        flag_z;
        logic        flag_s;
        logic        flag_o;
        logic        branch_taken;
        logic [23:0] start_addr;
        logic [23:0] target_addr;
        logic [15:0] xfer_count;
        logic        mismatch;
        logic        null_low;
    } ssd_req_t;

    typedef struct packed {
        logic        legal;
        logic        indirect;
        logic [3:0]  length;
        logic [19:0] cycles;
        ssd_mode_t   dest_mode;
        logic        shift_left;
        logic [7:0]  shift_amount;
        logic [4:0]  sub_value;
        logic [7:0]  branch_disp;
        logic        disp_in_range;
        logic        cond_true;
    } ssd_res_t;

endpackage

// File: ssd_prog_mem.sv
// Program memory model supplying the byte ahead of the opcode
`timescale 1ns/100ps
module ssd_prog_mem
    import ssd_pkg::*;
(
    // Fetch address
    input  wire logic [1:0] ADDR_IN,
    // Fetched byte
    output logic      [7:0] DATA_OUT
);
    always_comb begin
        case (ADDR_IN)
            2'h0:    DATA_OUT = SSD_INDIRECT_PREFIX;
            2'h1:    DATA_OUT = 8'h08;
            default: DATA_OUT = 8'hF6;
        endcase
    end
endmodule

// File: shift_subtract_condset_decoder_tb_top.sv
// Self-checking bench of the shift, subtract and compare decoder
`timescale 1ns/100ps
module shift_subtract_condset_decoder_tb_top;
    import ssd_pkg::*;
    logic       clk = 0;
    logic       rst_n = 0;
    logic       vld = 0;
    ssd_req_t   r = '0;
    logic       done;
    ssd_res_t   res;
    logic [1:0] ma = 2'h0;
    logic [7:0] mb;
    int         err_count = 0;
    int         n_checks = 0;
    logic [4:0] mc [8] = '{5'h12, 5'h02, 5'h00, 5'h04,
                           5'h08, 5'h0C, 5'h0F, 5'h0E};
    logic [3:0] ml [8] = '{4'h2, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h5};
    ssd_mode_t  md [8] = '{SSD_MODE_GEN_REG, SSD_MODE_ADDR_REG,
                           SSD_MODE_ADDR_IND, SSD_MODE_BRANCH_DISPLACEMENT_BYTE, SSD_MODE_DSP16,
                           SSD_MODE_DSP24, SSD_MODE_ABS16, SSD_MODE_ABS24};
    ssd_decoder uut (.CLK_IN(clk), .RST_N_IN(rst_n), .REQ_VALID_IN(vld),
                     .REQ_IN(r), .DONE_OUT(done), .RESULT_OUT(res));
    ssd_prog_mem mem (.ADDR_IN(ma), .DATA_OUT(mb));
    always #50 clk = ~clk;
    task test_done;
        $display("mismatches %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task bad(input string m);
        err_count++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task set(input ssd_op_t o, input logic [4:0] d);
        r = '0;
        r.op = o;
        r.dest_code = d;
    endtask
    // Result is registered: it must be up by the next falling edge.
    // Valid stays up between calls, since back-to-back requests are legal
    task go;
        vld = 1;
        @(negedge clk);
        n_checks++;
        if (done !== 1'b1) bad("no done pulse");
    endtask
    task chk(input logic l, input logic [3:0] n, input logic [19:0] c);
        go();
        n_checks++;
        if (res.legal !== l || res.length !== n || res.cycles !== c)
            bad("legal, length or cycles wrong");
    endtask
    task t_modes;
        for (int i = 0; i < 8; i++) begin
            set(SSD_ARITH_SHIFT_IMM, mc[i]);
            chk(1'b1, ml[i], (i < 2) ? 20'h2 : 20'h4);
            if (res.dest_mode !== md[i]) bad("mode wrong");
        end
        set(SSD_ARITH_SHIFT_IMM, 5'h14);
        go();
        if (res.legal !== 1'b0) bad("undefined code taken");
    endtask
    task t_indirect;
        set(SSD_ARITH_SHIFT_IMM, 5'h00);
        r.lead_valid = 1;
        r.lead_byte = mb;
        r.imm_field = 4'hF;
        chk(1'b1, 4'h3, 20'h7);
        if (res.indirect !== 1'b1) bad("prefix not seen");
        if (res.shift_left !== 0 || res.shift_amount !== 8'h08)
            bad("negative count");
        ma = 2'h1;
        #1 r.lead_byte = mb;
        go();
        if (res.legal !== 1'b0) bad("wrong prefix taken");
        set(SSD_ARITH_SHIFT_IMM, 5'h12);
        r.imm_field = 4'h7;
        go();
        if (res.shift_left !== 1 || res.shift_amount !== 8'h08)
            bad("positive count");
    endtask
    task t_shift_reg;
        set(SSD_CIRC_SHIFT_REG, 5'h13);
        r.count_high_byte = 8'hFD;
        chk(1'b1, 4'h2, 20'h3);
        if (res.shift_left !== 0 || res.shift_amount !== 8'h03)
            bad("register count");
        r.size_word = 1;
        chk(1'b0, 4'h2, 20'h3);
        set(SSD_ARITH_SHIFT_REG, 5'h04);
        r.count_high_byte = 8'h05;
        chk(1'b1, 4'h3, 20'h5);
        if (res.shift_left !== 1 || res.shift_amount !== 8'h05)
            bad("register count");
    endtask
    task t_long;
        set(SSD_ARITH_SHIFT_LONG_IMM, 5'h12);
        chk(1'b1, 4'h3, 20'h6);
        set(SSD_ARITH_SHIFT_LONG_IMM, 5'h10);
        go();
        if (res.legal !== 1'b0) bad("long shift upper pair");
        set(SSD_ARITH_SHIFT_LONG_IMM, 5'h0E);
        chk(1'b1, 4'h6, 20'h8);
    endtask
    task t_sub;
        set(SSD_SUB_BORROW_IMM, 5'h12);
        chk(1'b1, 4'h4, 20'h1);
        set(SSD_SUB_BORROW_IMM, 5'h0F);
        r.size_word = 1;
        chk(1'b1, 4'h7, 20'h3);
        set(SSD_SUB_BORROW_REG, 5'h12);
        r.src_code = 5'h12;
        chk(1'b1, 4'h3, 20'h1);
        r.src_code = 5'h00;
        chk(1'b1, 4'h3, 20'h3);
        set(SSD_SUB_BORROW_REG, 5'h0E);
        r.src_code = 5'h0C;
        chk(1'b1, 4'h9, 20'h4);
    endtask
    task t_branch;
        logic [3:0] im [4] = '{4'h0, 4'h1, 4'h8, 4'hF};
        logic [4:0] sv [4] = '{5'h00, 5'h1F, 5'h08, 5'h01};
        set(SSD_SUB_BRANCH_NZ, 5'h12);
        r.branch_taken = 1;
        r.start_addr = 24'h000100;
        r.target_addr = 24'h0000F0;
        chk(1'b1, 4'h3, 20'h4);
        if (res.branch_disp !== 8'hEE || res.disp_in_range !== 1'b1)
            bad("branch offset");
        for (int i = 0; i < 4; i++) begin
            r.imm_field = im[i];
            go();
            if (res.sub_value !== sv[i]) bad("subtrahend");
        end
        set(SSD_SUB_BRANCH_NZ, 5'h04);
        r.start_addr = 24'h000100;
        r.target_addr = 24'h000200;
        chk(1'b1, 4'h4, 20'h4);
        if (res.disp_in_range !== 1'b0) bad("far target");
    endtask
    task t_store;
        for (int i = 0; i < 16; i++) begin
            set(SSD_STORE_ON_COND, 5'h12);
            r.cond_code = i[3:0];
            chk(i[2:0] != 3'h7, 4'h2, 20'h1);
            if (i[2:0] != 3'h7 && res.cond_true !== ~i[3])
                bad("condition");
        end
        r.flag_c = 1;
        r.cond_code = 4'h8;
        go();
        if (res.cond_true !== 1'b1) bad("carry condition");
        set(SSD_STORE_ON_COND, 5'h0E);
        chk(1'b1, 4'h5, 20'h1);
    endtask
    task t_cmp;
        logic [19:0] ex [4] = '{20'hB, 20'hE, 20'hD, 20'hF};
        set(SSD_STRING_COMPARE, 5'h12);
        r.xfer_count = 16'h0004;
        chk(1'b1, 4'h2, 20'h12);
        r.size_word = 1;
        r.xfer_count = 16'h0003;
        for (int i = 0; i < 4; i++) begin
            r.mismatch = i[0];
            r.null_low = i[1];
            chk(1'b1, 4'h2, ex[i]);
        end
    endtask
    initial begin
        #2000000 bad("run hung");
        test_done();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        n_checks++;
        if (done !== 1'b0 || res !== '0) bad("reset state");
        t_modes();
        t_indirect();
        t_shift_reg();
        t_long();
        t_sub();
        t_branch();
        t_store();
        t_cmp();
        test_done();
    end
endmodule
